// *** common/radio_ctl_pkg.sv ***
// Package: register map, field layout and state codes of the radio control
`default_nettype none
package radio_ctl_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [5:0] RX_TIMEOUT_CONFIG_OFS = 6'h15;
	localparam logic [5:0] CHAN_EXIT_CONFIG_OFS  = 6'h16;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int RSSI_EARLY_END_BIT   = 4;
	localparam int QUALITY_CHECK_BIT    = 3;
	localparam int RX_TIME_LSB          = 0;
	localparam int CLEAR_SELECT_LSB     = 4;
	localparam int AFTER_RECEIVE_LSB    = 2;
	localparam int AFTER_SEND_LSB       = 0;
	// ---------------------------------------------------------------
	// Reset values and no-timeout code
	// ---------------------------------------------------------------
	localparam logic [2:0] RX_TIME_RST        = 3'h7;
	localparam logic [1:0] CLEAR_SELECT_RST   = 2'h3;
	localparam logic [1:0] AFTER_RECEIVE_RST  = 2'h0;
	localparam logic [1:0] AFTER_SEND_RST     = 2'h0;
	localparam logic [2:0] RX_TIME_NO_TIMEOUT = 3'h7;
	// ---------------------------------------------------------------
	// Timing counts
	// ---------------------------------------------------------------
	localparam logic [3:0] CARRIER_WAIT_SYMBOLS = 4'h8;
	localparam int         PERIOD_SHIFT_BASE    = 3;
	localparam int         RESOLUTION_SHIFT     = 5;
	// ---------------------------------------------------------------
	// Radio states, exit selections and clear-flag selections
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE     = 2'b00,
		ST_SYNTH_ON = 2'b01,
		ST_TX       = 2'b10,
		ST_RX       = 2'b11
	} radio_state_t;
	localparam logic [1:0] EXIT_IDLE  = 2'h0;
	localparam logic [1:0] EXIT_SYNTH = 2'h1;
	localparam logic [1:0] EXIT_TX    = 2'h2;
	localparam logic [1:0] EXIT_RX    = 2'h3;
	localparam logic [1:0] RXX_STAY   = 2'h3;
	localparam logic [1:0] RXX_TX     = 2'h2;
	localparam logic [1:0] TXX_STAY   = 2'h2;
	localparam logic [1:0] TXX_RX     = 2'h3;
	localparam logic [1:0] CLR_ALWAYS = 2'h0;
	localparam logic [1:0] CLR_RSSI   = 2'h1;
	localparam logic [1:0] CLR_NO_PKT = 2'h2;
endpackage
`default_nettype wire

// *** dv/host_model.sv ***
// Host model: writes and reads the radio config registers
`timescale 1ns/1ns
`default_nettype none
module host_model
(
	input  wire logic       mclk,
	input  wire logic [7:0] regRdData,
	output logic      [5:0] regAddr,
	output logic            regWrEn,
	output logic      [7:0] regWrData,
	output logic      [1:0] wakeTimerResolution
);
	// -------------------------------------------------
	// Register access
	// -------------------------------------------------
	initial
	begin
		regAddr = 6'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		wakeTimerResolution = 2'h0;
	end
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge mclk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		@(posedge mclk);
		#1 d = regRdData;
	endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench: radio timeout, clear flag and exit states
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// -------------------------------------------------
	// Stimulus and checks
	// -------------------------------------------------
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic [5:0] pl = 6'h00;
	logic [4:0] lv = 5'h00;
	logic [15:0] evPer = 16'h0010;
	logic [5:0] regAddr;
	logic       regWrEn;
	logic [7:0] regWrData;
	logic [1:0] wakeRes;
	logic [7:0] regRdData;
	logic [1:0] radioState;
	logic       channelClearFlag;
	logic       rxAbandoned;
	logic       txPreambleRestart;
	logic [7:0] d;
	int         errors = 0;
	int         n_checks = 0;
	int         nAb = 0;
	int         nPre = 0;
	int         p;
	always #50 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if (rxAbandoned === 1'b1)
			nAb++;
		if (txPreambleRestart === 1'b1)
			nPre++;
	end
	host_model u_host (.mclk(mclk), .regRdData(regRdData),
		.regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .wakeTimerResolution(wakeRes));
	radio_rx_timeout u_dut (.mclk(mclk), .rst(rst), .ce(ce),
		.regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .startRx(pl[0]), .startTx(pl[1]),
		.rxPacketDone(pl[2]), .txPacketDone(pl[3]),
		.syncFound(lv[0]), .preambleQualityFlag(lv[1]),
		.carrierSense(lv[2]), .rssiBelowThreshold(lv[3]),
		.askMode(lv[4]), .symbolTick(pl[4]), .rcTick(pl[5]),
		.wakeEventPeriod(evPer), .wakeTimerResolution(wakeRes),
		.regRdData(regRdData), .radioState(radioState),
		.channelClearFlag(channelClearFlag),
		.rxAbandoned(rxAbandoned),
		.txPreambleRestart(txPreambleRestart));
	task automatic close_out;
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic rs;
		@(posedge mclk);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
	endtask
	task automatic pulse(input int b);
		@(posedge mclk);
		pl[b] <= 1'b1;
		@(posedge mclk);
		pl <= 6'h00;
	endtask
	task automatic tmo(input logic [7:0] c, input logic [4:0] l,
		input logic [1:0] e);
		int a;
		rs();
		u_host.wr(6'h15, c);
		@(posedge mclk);
		lv <= l;
		a = nAb;
		pulse(0);
		pulse(5);
		#1 chk(radioState, 8'h03);
		pulse(5);
		cyc(2);
		#1 chk(radioState, e);
		chk(nAb - a, e == 2'h0);
	endtask
	initial
	begin
		cyc(2);
		rst <= 1'b0;
		u_host.rd(6'h15, d);
		chk(d, 8'h07);
		u_host.rd(6'h16, d);
		chk(d, 8'h30);
		u_host.rd(6'h2a, d);
		chk(d, 8'h00);
		u_host.wr(6'h15, 8'hff);
		u_host.rd(6'h15, d);
		chk(d, 8'h1f);
		for (int m = 0; m < 8; m++)
		begin
			u_host.wr(6'h16, {2'h0, m[2:1], 4'h0});
			@(posedge mclk);
			lv <= {1'b0, m[0], 3'h0};
			cyc(2);
			#1 chk(channelClearFlag, m[1] ? m[0] : 1'b1);
		end
		u_host.wr(6'h16, 8'h20);
		@(posedge mclk);
		lv <= 5'h01;
		pulse(0);
		cyc(2);
		#1 chk(channelClearFlag, 8'h00);
		pulse(2);
		cyc(2);
		#1 chk(channelClearFlag, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			rs();
			u_host.wr(6'h16, {4'h0, k[1:0], 2'h0});
			pulse(0);
			#1 chk(radioState, 8'h03);
			pulse(2);
			#1 chk(radioState, k[1:0]);
		end
		@(posedge mclk);
		lv <= 5'h00;
		for (int k = 0; k < 4; k++)
		begin
			rs();
			u_host.wr(6'h16, {6'h00, k[1:0]});
			p = nPre;
			pulse(1);
			#1 chk(radioState, 8'h02);
			pulse(3);
			#1 chk(radioState, k[1:0]);
			cyc(2);
			chk(nPre - p, k == 2);
		end
		tmo(8'h00, 5'h00, 2'h0);
		tmo(8'h00, 5'h01, 2'h3);
		tmo(8'h00, 5'h02, 2'h0);
		tmo(8'h08, 5'h02, 2'h3);
		tmo(8'h07, 5'h00, 2'h3);
		tmo(8'h17, 5'h14, 2'h3);
		tmo(8'h17, 5'h10, 2'h3);
		repeat (7) pulse(4);
		#1 chk(radioState, 8'h03);
		pulse(4);
		cyc(2);
		#1 chk(radioState, 8'h00);
		@(posedge mclk);
		lv <= 5'h00;
		p = nAb;
		pulse(0);
		#1 chk(radioState, 8'h03);
		cyc(2);
		#1 chk(radioState, 8'h00);
		chk(nAb - p, 8'h01);
		@(posedge mclk);
		evPer <= 16'h0020;
		tmo(8'h00, 5'h00, 2'h3);
		@(posedge mclk);
		ce <= 1'b0;
		pulse(2);
		#1 chk(radioState, 8'h03);
		@(posedge mclk);
		ce <= 1'b1;
		close_out();
	end
	initial
	begin
		cyc(5000);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire

// *** hdl/radio_rx_timeout.sv ***
// Radio receive timeout, clear-channel indication and exit state control
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Early-end set: no carrier ends search; ASK allows 8 symbols first.
// - At expiry keep receiving on sync, or preamble quality when checked.
// - Three-bit timeout field, reset 7, scaled from wake event period.
// - Timeout counter counts RC oscillator periods, wake mode not required.
// - Clear flag follows two-bit select: always, RSSI low, no packet, both.
// - After reception go idle, synth-on, transmit or stay in receive.
// - After sending go idle, synth-on, stay sending preamble, or receive.
module radio_rx_timeout
#(parameter int TIMER_W = 32)
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [5:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       startRx,
	input  wire logic       startTx,
	input  wire logic       rxPacketDone,
	input  wire logic       txPacketDone,
	input  wire logic       syncFound,
	input  wire logic       preambleQualityFlag,
	input  wire logic       carrierSense,
	input  wire logic       rssiBelowThreshold,
	input  wire logic       askMode,
	input  wire logic       symbolTick,
	input  wire logic       rcTick,
	input  wire logic [15:0] wakeEventPeriod,
	input  wire logic [1:0] wakeTimerResolution,
	output logic [7:0]      regRdData,
	output logic [1:0]      radioState,
	output logic            channelClearFlag,
	output logic            rxAbandoned,
	output logic            txPreambleRestart
);
	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic       rssiEarlyEnd_ff, nxt_rssiEarlyEnd;
	logic       qualCheck_ff, nxt_qualCheck;
	logic [2:0] rxTime_ff, nxt_rxTime;
	logic [1:0] clearSel_ff, nxt_clearSel;
	logic [1:0] afterRx_ff, nxt_afterRx;
	logic [1:0] afterTx_ff, nxt_afterTx;
	logic [7:0] rdData_ff, nxt_rdData;
	always_comb
	begin
		nxt_rssiEarlyEnd = rssiEarlyEnd_ff;
		nxt_qualCheck = qualCheck_ff;
		nxt_rxTime = rxTime_ff;
		nxt_clearSel = clearSel_ff;
		nxt_afterRx = afterRx_ff;
		nxt_afterTx = afterTx_ff;
		if (regWrEn && regAddr == radio_ctl_pkg::RX_TIMEOUT_CONFIG_OFS)
		begin
			nxt_rssiEarlyEnd =
				regWrData[radio_ctl_pkg::RSSI_EARLY_END_BIT];
			nxt_qualCheck = regWrData[radio_ctl_pkg::QUALITY_CHECK_BIT];
			nxt_rxTime = regWrData[radio_ctl_pkg::RX_TIME_LSB +: 3];
		end
		if (regWrEn && regAddr == radio_ctl_pkg::CHAN_EXIT_CONFIG_OFS)
		begin
			nxt_clearSel = regWrData[radio_ctl_pkg::CLEAR_SELECT_LSB +: 2];
			nxt_afterRx = regWrData[radio_ctl_pkg::AFTER_RECEIVE_LSB +: 2];
			nxt_afterTx = regWrData[radio_ctl_pkg::AFTER_SEND_LSB +: 2];
		end
		case (regAddr)
			radio_ctl_pkg::RX_TIMEOUT_CONFIG_OFS:
				nxt_rdData = {3'h0, nxt_rssiEarlyEnd, nxt_qualCheck,
					nxt_rxTime};
			radio_ctl_pkg::CHAN_EXIT_CONFIG_OFS:
				nxt_rdData = {2'h0, nxt_clearSel, nxt_afterRx, nxt_afterTx};
			default: nxt_rdData = 8'h00;
		endcase
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rssiEarlyEnd_ff <= 1'b0;
			qualCheck_ff <= 1'b0;
			rxTime_ff <= radio_ctl_pkg::RX_TIME_RST;
			clearSel_ff <= radio_ctl_pkg::CLEAR_SELECT_RST;
			afterRx_ff <= radio_ctl_pkg::AFTER_RECEIVE_RST;
			afterTx_ff <= radio_ctl_pkg::AFTER_SEND_RST;
			rdData_ff <= 8'h00;
		end
		else if (ce)
		begin
			rssiEarlyEnd_ff <= nxt_rssiEarlyEnd;
			qualCheck_ff <= nxt_qualCheck;
			rxTime_ff <= nxt_rxTime;
			clearSel_ff <= nxt_clearSel;
			afterRx_ff <= nxt_afterRx;
			afterTx_ff <= nxt_afterTx;
			rdData_ff <= nxt_rdData;
		end
	end
	// ---------------------------------------------------------------
	// Radio state, timeout and clear channel
	// ---------------------------------------------------------------
	radio_ctl_pkg::radio_state_t state_ff, nxt_state;
	logic [TIMER_W-1:0] timer_ff, nxt_timer;
	logic [3:0]         symCount_ff, nxt_symCount;
	logic               pktActive_ff, nxt_pktActive;
	logic               clear_ff, nxt_clear;
	logic               abandon_ff, nxt_abandon;
	logic               restart_ff, nxt_restart;
	logic [TIMER_W-1:0] timeoutLen;
	logic [TIMER_W-1:0] scaledPeriod;
	logic               qualOk;
	always_comb
	begin
		scaledPeriod = TIMER_W'(wakeEventPeriod)
			<< (radio_ctl_pkg::RESOLUTION_SHIFT * wakeTimerResolution);
		timeoutLen = scaledPeriod
			>> (radio_ctl_pkg::PERIOD_SHIFT_BASE + rxTime_ff);
		qualOk = syncFound || pktActive_ff
			|| (qualCheck_ff && preambleQualityFlag);
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_symCount = symCount_ff;
		nxt_pktActive = pktActive_ff;
		nxt_abandon = 1'b0;
		nxt_restart = 1'b0;
		case (state_ff)
			radio_ctl_pkg::ST_IDLE, radio_ctl_pkg::ST_SYNTH_ON:
			begin
				if (startRx)
					nxt_state = radio_ctl_pkg::ST_RX;
				else if (startTx)
					nxt_state = radio_ctl_pkg::ST_TX;
			end
			radio_ctl_pkg::ST_RX:
			begin
				if (syncFound)
					nxt_pktActive = 1'b1;
				if (rcTick)
					nxt_timer = timer_ff + 1'b1;
				if (symbolTick && symCount_ff
					!= radio_ctl_pkg::CARRIER_WAIT_SYMBOLS)
					nxt_symCount = symCount_ff + 4'h1;
				if (rxPacketDone)
				begin
					case (afterRx_ff)
						radio_ctl_pkg::EXIT_SYNTH:
							nxt_state = radio_ctl_pkg::ST_SYNTH_ON;
						radio_ctl_pkg::RXX_TX:
							nxt_state = radio_ctl_pkg::ST_TX;
						radio_ctl_pkg::RXX_STAY:
							nxt_state = radio_ctl_pkg::ST_RX;
						default:
							nxt_state = radio_ctl_pkg::ST_IDLE;
					endcase
					nxt_pktActive = 1'b0;
				end
				else if (!pktActive_ff && !syncFound && rssiEarlyEnd_ff
					&& (askMode ? (!carrierSense && symCount_ff
					== radio_ctl_pkg::CARRIER_WAIT_SYMBOLS)
					: !carrierSense))
				begin
					nxt_state = radio_ctl_pkg::ST_IDLE;
					nxt_abandon = 1'b1;
				end
				else if (rxTime_ff != radio_ctl_pkg::RX_TIME_NO_TIMEOUT
					&& rcTick && timer_ff + 1'b1 >= timeoutLen
					&& !pktActive_ff)
				begin
					if (qualOk)
						nxt_pktActive = 1'b1;
					else
					begin
						nxt_state = radio_ctl_pkg::ST_IDLE;
						nxt_abandon = 1'b1;
					end
				end
				if (carrierSense)
					nxt_symCount = radio_ctl_pkg::CARRIER_WAIT_SYMBOLS;
			end
			radio_ctl_pkg::ST_TX:
			begin
				if (txPacketDone)
				begin
					case (afterTx_ff)
						radio_ctl_pkg::EXIT_SYNTH:
							nxt_state = radio_ctl_pkg::ST_SYNTH_ON;
						radio_ctl_pkg::TXX_STAY:
						begin
							nxt_state = radio_ctl_pkg::ST_TX;
							nxt_restart = 1'b1;
						end
						radio_ctl_pkg::TXX_RX:
							nxt_state = radio_ctl_pkg::ST_RX;
						default:
							nxt_state = radio_ctl_pkg::ST_IDLE;
					endcase
				end
			end
			default:
				nxt_state = radio_ctl_pkg::ST_IDLE;
		endcase
		// Fresh search on every entry into receive
		if (nxt_state == radio_ctl_pkg::ST_RX
			&& (state_ff != radio_ctl_pkg::ST_RX || rxPacketDone))
		begin
			nxt_timer = '0;
			nxt_symCount = 4'h0;
			nxt_pktActive = 1'b0;
		end
		case (clearSel_ff)
			radio_ctl_pkg::CLR_ALWAYS: nxt_clear = 1'b1;
			radio_ctl_pkg::CLR_RSSI:   nxt_clear = rssiBelowThreshold;
			radio_ctl_pkg::CLR_NO_PKT: nxt_clear = !nxt_pktActive;
			default: nxt_clear = rssiBelowThreshold && !nxt_pktActive;
		endcase
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_ff <= radio_ctl_pkg::ST_IDLE;
			timer_ff <= '0;
			symCount_ff <= 4'h0;
			pktActive_ff <= 1'b0;
			clear_ff <= 1'b0;
			abandon_ff <= 1'b0;
			restart_ff <= 1'b0;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			symCount_ff <= nxt_symCount;
			pktActive_ff <= nxt_pktActive;
			clear_ff <= nxt_clear;
			abandon_ff <= nxt_abandon;
			restart_ff <= nxt_restart;
		end
	end
	assign regRdData = rdData_ff;
	assign radioState = state_ff;
	assign channelClearFlag = clear_ff;
	assign rxAbandoned = abandon_ff;
	assign txPreambleRestart = restart_ff;
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	rx_exit_map_a: assert property (ce && state_ff == radio_ctl_pkg::ST_RX
		&& rxPacketDone |=> radioState == $past(afterRx_ff))
		else $error("Wrong state after reception");
	tx_exit_map_a: assert property (ce && state_ff == radio_ctl_pkg::ST_TX
		&& txPacketDone |=> radioState == $past(afterTx_ff))
		else $error("Wrong state after sending");
	tx_preamble_a: assert property (txPreambleRestart |->
		radioState == radio_ctl_pkg::ST_TX && $past(afterTx_ff) == 2'h2)
		else $error("Preamble restart without stay setting");
	clear_always_a: assert property (ce && clearSel_ff == 2'h0
		|=> channelClearFlag)
		else $error("Clear flag low in always mode");
	clear_rssi_a: assert property (ce && clearSel_ff == 2'h1
		|=> channelClearFlag == $past(rssiBelowThreshold))
		else $error("Clear flag not following RSSI");
	no_timeout_a: assert property (rxAbandoned |->
		$past(rxTime_ff) != 3'h7 || $past(rssiEarlyEnd_ff))
		else $error("Abandon with timeout disabled");
	abandon_idle_a: assert property (rxAbandoned |->
		radioState == radio_ctl_pkg::ST_IDLE
		&& $past(state_ff) == radio_ctl_pkg::ST_RX)
		else $error("Abandon did not return to idle");
	qual_keep_a: assert property (ce && state_ff == radio_ctl_pkg::ST_RX
		&& !rssiEarlyEnd_ff && syncFound |=> !rxAbandoned)
		else $error("Reception abandoned with sync found");
	ask_wait_a: assert property (ce && state_ff == radio_ctl_pkg::ST_RX
		&& askMode && symCount_ff < 4'h8 && !rxPacketDone
		|=> !rxAbandoned || $past(rxTime_ff) != 3'h7)
		else $error("ASK search ended before 8 symbols");
	timer_reset_a: assert property (ce && state_ff == radio_ctl_pkg::ST_IDLE
		&& startRx |=> timer_ff == '0 ##1 (timer_ff <= 1))
		else $error("Timer not cleared on receive entry");
	rx_stay_c: cover property (state_ff == radio_ctl_pkg::ST_RX
		&& rxPacketDone && afterRx_ff == 2'h3);
	abandon_c: cover property (rxAbandoned);
	tx_to_rx_c: cover property (state_ff == radio_ctl_pkg::ST_TX
		##1 state_ff == radio_ctl_pkg::ST_RX);
endmodule
`default_nettype wire
